// ===== sim/smc_host.sv
/*
 Host model: register bus writes and reads, and the receive level.
 Assumes the bank samples its inputs on the rising edge of clk.
*/
`timescale 1ns/100ps
`default_nettype none
module smc_host (
    input  wire logic               clk,
    output var  logic               wr_en,
    output var  logic               rd_en,
    output var  smc_pkg::smc_addr_t addr,
    output var  smc_pkg::smc_byte_t wr_data,
    output var  logic               rx_active
);
    import smc_pkg::*;
    initial begin
        wr_en = 1'h0;
        rd_en = 1'h0;
        addr = 6'h00;
        wr_data = 8'h00;
        rx_active = 1'h0;
    end
    // Released lines show inverted values, so stale data is never mistaken
    task automatic wr(input smc_addr_t a, input smc_byte_t d);
        @(negedge clk);
        wr_en = 1'h1;
        addr = a;
        wr_data = d;
        @(negedge clk);
        wr_en = 1'h0;
        addr = ~a;
        wr_data = ~d;
    endtask
    task automatic rd(input smc_addr_t a);
        @(negedge clk);
        rd_en = 1'h1;
        addr = a;
        @(negedge clk);
        rd_en = 1'h0;
        addr = ~a;
    endtask
    // Callers finish all carrier bytes before raising this
    task automatic rx(input logic v);
        @(negedge clk);
        rx_active = v;
    endtask
endmodule
`default_nettype wire

// ===== sim/synth_modem_config_regs_tb.sv
/*
 Self-checking bench for the configuration register bank.
 Assumes smc_regs and the host model smc_host.
*/
`timescale 1ns/100ps
`default_nettype none
module synth_modem_config_regs_tb;
    import smc_pkg::*;
    logic clk = 1'h0, reset = 1'h1, wr_en, rd_en, rx_active, rd_valid, vendor_bit;
    smc_addr_t addr;
    smc_byte_t wr_data, rd_data;
    logic [4:0] intermediate_tuning_value;
    smc_word_t carrier_base_word, synth_word;
    logic [1:0] filter_bw_exponent, filter_bw_mantissa;
    logic [3:0] symbol_rate_exponent;
    logic [8:0] symbol_rate_mantissa;
    logic [7:0] exp_q [7] = '{8'h0f, 8'h00, 8'h1e, 8'hc4, 8'hec, 8'h8c, 8'h22};
    logic [31:0] seed = 32'hbbcc_2540;
    int n_errors = 0, compares = 0;
    always #50 clk = ~clk;
    smc_host host (.clk, .wr_en, .rd_en, .addr, .wr_data, .rx_active);
    smc_regs dut (.clk, .reset, .wr_en, .rd_en, .addr, .wr_data, .rx_active, .rd_data,
        .rd_valid, .intermediate_tuning_value, .vendor_bit, .carrier_base_word,
        .synth_word, .filter_bw_exponent, .filter_bw_mantissa, .symbol_rate_exponent,
        .symbol_rate_mantissa);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [23:0] exp_synth(input logic rx);
        logic [23:0] ifw;
        ifw = rx ? {13'h0000, exp_q[0][4:0], 6'h00} : 24'h00_0000;
        return {2'h0, exp_q[2][5:0], exp_q[3], exp_q[4]}
            + {{14{exp_q[1][7]}}, exp_q[1], 2'h0} - ifw;
    endfunction
    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Read data and its valid flag are judged together
    task automatic cmp_rd(input smc_addr_t a, input logic [7:0] exp);
        host.rd(a);
        cmp(24'({rd_valid, rd_data}), 24'({1'h1, exp}));
    endtask
    task automatic chk_out();
        cmp(24'(intermediate_tuning_value), 24'(exp_q[0][4:0]));
        cmp(24'(vendor_bit), 24'(exp_q[0][5]));
        cmp(carrier_base_word, {2'h0, exp_q[2][5:0], exp_q[3], exp_q[4]});
        cmp(synth_word, exp_synth(rx_active));
        cmp(24'({filter_bw_exponent, filter_bw_mantissa}), 24'(exp_q[5][7:4]));
        cmp(24'(symbol_rate_exponent), 24'(exp_q[5][3:0]));
        cmp(24'(symbol_rate_mantissa), {15'h0001, exp_q[6]});
    endtask
    task automatic put(input int i, input logic [7:0] d);
        host.wr(6'(i + 11), d);
        exp_q[i] = (i == 0 || i == 2) ? (d & 8'h3f) : d;
    endtask
    task automatic end_of_test();
        $display("n_errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #(4000 * 100);
        n_errors++;
        end_of_test();
    end
    initial begin
        repeat (8) @(negedge clk);
        reset = 1'h0;
        chk_out();
        for (int i = 0; i < 7; i++) cmp_rd(6'(i + 11), exp_q[i]);
        put(2, 8'hff);
        put(0, 8'hff);
        put(1, 8'h80);
        host.rx(1'h1);
        repeat (2) @(negedge clk);
        chk_out();
        cmp_rd(6'h0d, 8'h3f);
        cmp_rd(6'h0b, 8'h3f);
        host.wr(6'h12, 8'h55);
        cmp_rd(6'h12, 8'h00);
        cmp_rd(6'h0a, 8'h00);
        for (int k = 0; k < 200; k++) begin
            int i;
            i = int'(rnd() % 7);
            host.rx(1'h0);
            put(i, 8'(rnd()));
            host.rx(1'(rnd()));
            repeat (2) @(negedge clk);
            chk_out();
            cmp_rd(6'(i + 11), exp_q[i]);
        end
        end_of_test();
    end
endmodule
`default_nettype wire

// ===== verilog/smc_defs.svh
/*
 Register offsets, field positions and reset values for the synthesizer and
 modem configuration register bank. Assumes byte-wide registers on a 6-bit
 register address.
*/
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH

`define SMC_ADDR_SYNTH_CONTROL_IF          6'h0b
`define SMC_ADDR_SYNTH_CARRIER_BASE_WORD_OFFSET         6'h0c
`define SMC_ADDR_CARRIER_WORD_HIGH         6'h0d
`define SMC_ADDR_CARRIER_WORD_MIDDLE       6'h0e
`define SMC_ADDR_CARRIER_WORD_LOW          6'h0f
`define SMC_ADDR_MODEM_BANDWIDTH_RATE_EXP  6'h10
`define SMC_ADDR_MODEM_RATE_MANTISSA       6'h11

`define SMC_RST_SYNTH_CONTROL_IF           8'h0f
`define SMC_RST_SYNTH_CARRIER_BASE_WORD_OFFSET          8'h00
`define SMC_RST_CARRIER_WORD_HIGH          8'h1e
`define SMC_RST_CARRIER_WORD_MIDDLE        8'hc4
`define SMC_RST_CARRIER_WORD_LOW           8'hec
`define SMC_RST_MODEM_BANDWIDTH_RATE_EXP   8'h8c
`define SMC_RST_MODEM_RATE_MANTISSA        8'h22

// Writable bits of the control and high carrier byte registers; the others take all eight bits
`define SMC_MASK_SYNTH_CONTROL_IF          8'h3f
`define SMC_MASK_CARRIER_WORD_HIGH         8'h3f

`define SMC_IF_LSB                         0
`define SMC_IF_MSB                         4
`define SMC_VENDOR_BIT                     5
`define SMC_BW_EXP_LSB                     6
`define SMC_BW_MAN_LSB                     4
`define SMC_RATE_EXP_LSB                   0
`define SMC_RATE_EXP_MSB                   3

`endif

// ===== verilog/smc_pkg.sv
/*
 Types shared by the synthesizer and modem configuration register bank.
 Assumes the constants come from smc_defs.svh.
*/
package smc_pkg;
    typedef logic [5:0]  smc_addr_t;
    typedef logic [7:0]  smc_byte_t;
    typedef logic [23:0] smc_word_t;
endpackage

// ===== verilog/smc_regs.sv
/*
 Synthesizer and modem configuration register bank: byte registers written
 and read by the serial interface front end, decoded into settings for the
 synthesizer, mixer, decimator and symbol timing logic.
 Assumes a front end on clk that presents one-cycle write and read strobes.
*/
`timescale 1ns/100ps
`default_nettype none
`include "smc_defs.svh"

module smc_regs
    import smc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    input  wire smc_pkg::smc_addr_t addr,
    input  wire smc_pkg::smc_byte_t wr_data,
    input  wire logic              rx_active,
    output var  smc_pkg::smc_byte_t rd_data,
    output var  logic              rd_valid,
    output var  logic [4:0]        intermediate_tuning_value,
    output var  logic              vendor_bit,
    output var  smc_pkg::smc_word_t carrier_base_word,
    output var  smc_pkg::smc_word_t synth_word,
    output var  logic [1:0]        filter_bw_exponent,
    output var  logic [1:0]        filter_bw_mantissa,
    output var  logic [3:0]        symbol_rate_exponent,
    output var  logic [8:0]        symbol_rate_mantissa
);
    import smc_pkg::*;

    smc_byte_t ctl_q;
    smc_byte_t off_q;
    smc_byte_t hi_q;
    smc_byte_t mid_q;
    smc_byte_t lo_q;
    smc_byte_t mdm4_q;
    smc_byte_t mdm3_q;
    smc_byte_t rd_mux;
    smc_word_t base_w;
    smc_word_t off_ext;
    smc_word_t if_word;
    smc_word_t synth_d;
    logic      we_ctl;
    logic      we_off;
    logic      we_hi;
    logic      we_mid;
    logic      we_lo;
    logic      we_mdm4;
    logic      we_mdm3;

    function automatic logic hit(input smc_addr_t a, input smc_addr_t r);
        return wr_en && (a == r);
    endfunction

    assign we_ctl  = hit(addr, `SMC_ADDR_SYNTH_CONTROL_IF);
    assign we_off  = hit(addr, `SMC_ADDR_SYNTH_CARRIER_BASE_WORD_OFFSET);
    assign we_hi   = hit(addr, `SMC_ADDR_CARRIER_WORD_HIGH);
    assign we_mid  = hit(addr, `SMC_ADDR_CARRIER_WORD_MIDDLE);
    assign we_lo   = hit(addr, `SMC_ADDR_CARRIER_WORD_LOW);
    assign we_mdm4 = hit(addr, `SMC_ADDR_MODEM_BANDWIDTH_RATE_EXP);
    assign we_mdm3 = hit(addr, `SMC_ADDR_MODEM_RATE_MANTISSA);

    function automatic smc_byte_t read_select(input smc_addr_t a);
        smc_byte_t v;
        case (a)
            `SMC_ADDR_SYNTH_CONTROL_IF:         v = ctl_q;
            `SMC_ADDR_SYNTH_CARRIER_BASE_WORD_OFFSET:        v = off_q;
            `SMC_ADDR_CARRIER_WORD_HIGH:        v = hi_q;
            `SMC_ADDR_CARRIER_WORD_MIDDLE:      v = mid_q;
            `SMC_ADDR_CARRIER_WORD_LOW:         v = lo_q;
            `SMC_ADDR_MODEM_BANDWIDTH_RATE_EXP: v = mdm4_q;
            `SMC_ADDR_MODEM_RATE_MANTISSA:      v = mdm3_q;
            default:                            v = 8'h00;
        endcase
        return v;
    endfunction

    always_ff @(posedge clk) begin
        if (reset) begin
            ctl_q  <= `SMC_RST_SYNTH_CONTROL_IF;
            off_q  <= `SMC_RST_SYNTH_CARRIER_BASE_WORD_OFFSET;
            hi_q   <= `SMC_RST_CARRIER_WORD_HIGH;
            mid_q  <= `SMC_RST_CARRIER_WORD_MIDDLE;
            lo_q   <= `SMC_RST_CARRIER_WORD_LOW;
            mdm4_q <= `SMC_RST_MODEM_BANDWIDTH_RATE_EXP;
            mdm3_q <= `SMC_RST_MODEM_RATE_MANTISSA;
        end else begin
            // Masks drop unused bits so they can never read back
            if (we_ctl)
                ctl_q <= wr_data & `SMC_MASK_SYNTH_CONTROL_IF;
            if (we_off)
                off_q <= wr_data;
            if (we_hi)
                hi_q <= wr_data & `SMC_MASK_CARRIER_WORD_HIGH;
            if (we_mid)
                mid_q <= wr_data;
            if (we_lo)
                lo_q <= wr_data;
            if (we_mdm4)
                mdm4_q <= wr_data;
            if (we_mdm3)
                mdm3_q <= wr_data;
        end
    end

    // Unmapped addresses read zero
    assign rd_mux = read_select(addr);

    assign base_w  = {hi_q, mid_q, lo_q};
    // Offset step is four base steps, so shift the sign-extended value by two
    assign off_ext = {{14{off_q[7]}}, off_q, 2'b00};
    // IF step is 64 base steps
    assign if_word = {13'h0000, ctl_q[`SMC_IF_MSB:`SMC_IF_LSB], 6'b00_0000};
    assign synth_d = rx_active ? (base_w + off_ext - if_word) : (base_w + off_ext);

    always_ff @(posedge clk) begin
        if (reset) begin
            rd_data                   <= 8'h00;
            rd_valid                  <= 1'b0;
            intermediate_tuning_value <= 5'h0f;
            vendor_bit                <= 1'b0;
            carrier_base_word         <= 24'h1e_c4ec;
            synth_word                <= 24'h1e_c4ec;
            filter_bw_exponent        <= 2'h2;
            filter_bw_mantissa        <= 2'h0;
            symbol_rate_exponent      <= 4'hc;
            symbol_rate_mantissa      <= 9'h122;
        end else begin
            rd_data                   <= rd_en ? rd_mux : 8'h00;
            rd_valid                  <= rd_en;
            intermediate_tuning_value <= ctl_q[`SMC_IF_MSB:`SMC_IF_LSB];
            vendor_bit                <= ctl_q[`SMC_VENDOR_BIT];
            carrier_base_word         <= base_w;
            // Host must finish all carrier bytes first; no shadowing here
            synth_word                <= synth_d;
            filter_bw_exponent        <= mdm4_q[`SMC_BW_EXP_LSB +: 2];
            filter_bw_mantissa        <= mdm4_q[`SMC_BW_MAN_LSB +: 2];
            symbol_rate_exponent      <= mdm4_q[`SMC_RATE_EXP_MSB:`SMC_RATE_EXP_LSB];
            symbol_rate_mantissa      <= {1'b1, mdm3_q};
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    AST_HIGH_TOP_ZERO: assert property (
        rd_valid && $past(addr) == `SMC_ADDR_CARRIER_WORD_HIGH |-> rd_data[7:6] == 2'b00)
        else $error("High carrier byte top bits not zero");
    AST_CTL_TOP_ZERO: assert property (
        rd_valid && $past(addr) == `SMC_ADDR_SYNTH_CONTROL_IF |-> rd_data[7:6] == 2'b00)
        else $error("Control unused bits not zero");
    AST_IF_FOLLOWS: assert property (
        wr_en && addr == `SMC_ADDR_SYNTH_CONTROL_IF |-> ##2
        intermediate_tuning_value == $past(wr_data[4:0], 2))
        else $error("Intermediate tuning value did not follow write");
    AST_OFFSET_ADD: assert property (
        !rx_active ##1 !rx_active |-> synth_word ==
        24'(carrier_base_word + {{14{off_q[7]}}, off_q, 2'b00}) || $changed(off_q)
        || $changed(carrier_base_word))
        else $error("Offset not added to carrier word");
    AST_RX_SUB_IF: assert property (
        $past(rx_active) |-> synth_word == $past(24'(base_w + off_ext - if_word)))
        else $error("Intermediate frequency not subtracted in receive");
    // Output lags the bytes by one register stage
    AST_BASE_WORD: assert property (
        carrier_base_word == $past(base_w) && carrier_base_word[23:22] == 2'b00)
        else $error("Carrier word mismatch");
    AST_HIGH_WRITE_MASK: assert property (
        wr_en && addr == `SMC_ADDR_CARRIER_WORD_HIGH |-> ##2
        carrier_base_word[23:16] == {2'b00, $past(wr_data[5:0], 2)})
        else $error("High carrier byte write not masked");
    AST_MID_FOLLOWS: assert property (
        wr_en && addr == `SMC_ADDR_CARRIER_WORD_MIDDLE |-> ##2
        carrier_base_word[15:8] == $past(wr_data, 2))
        else $error("Middle carrier byte did not follow write");
    AST_LOW_FOLLOWS: assert property (
        wr_en && addr == `SMC_ADDR_CARRIER_WORD_LOW |-> ##2
        carrier_base_word[7:0] == $past(wr_data, 2))
        else $error("Low carrier byte did not follow write");
    AST_OFFSET_REG: assert property (
        wr_en && addr == `SMC_ADDR_SYNTH_CARRIER_BASE_WORD_OFFSET |=> off_q == $past(wr_data))
        else $error("Offset register did not take write");
    AST_VENDOR_FOLLOWS: assert property (
        wr_en && addr == `SMC_ADDR_SYNTH_CONTROL_IF |-> ##2
        vendor_bit == $past(wr_data[5], 2))
        else $error("Vendor bit did not follow write");
    AST_MANTISSA_FOLLOWS: assert property (
        wr_en && addr == `SMC_ADDR_MODEM_RATE_MANTISSA |-> ##2
        symbol_rate_mantissa == {1'b1, $past(wr_data, 2)})
        else $error("Rate mantissa did not follow write");
    AST_UNMAPPED_ZERO: assert property (
        rd_en && (addr < `SMC_ADDR_SYNTH_CONTROL_IF || addr > `SMC_ADDR_MODEM_RATE_MANTISSA)
        |=> rd_data == 8'h00)
        else $error("Unmapped read not zero");
    AST_RD_VALID_PULSE: assert property (
        rd_valid == $past(rd_en))
        else $error("Read valid not one cycle after strobe");
    // Idle zero keeps a stale byte from looking like fresh data
    AST_RD_IDLE_ZERO: assert property (
        !rd_valid |-> rd_data == 8'h00)
        else $error("Read data not zero while idle");
    AST_BW_FIELDS: assert property (
        wr_en && addr == `SMC_ADDR_MODEM_BANDWIDTH_RATE_EXP |-> ##2
        {filter_bw_exponent, filter_bw_mantissa} == $past(wr_data[7:4], 2))
        else $error("Bandwidth fields did not follow write");
    AST_RATE_EXP: assert property (
        wr_en && addr == `SMC_ADDR_MODEM_BANDWIDTH_RATE_EXP |-> ##2
        symbol_rate_exponent == $past(wr_data[3:0], 2))
        else $error("Rate exponent did not follow write");
    AST_HIDDEN_ONE: assert property (symbol_rate_mantissa[8] == 1'b1)
        else $error("Rate mantissa lost its leading one");

    COV_RX_TUNE: cover property (rx_active ##1 rx_active && ctl_q[4:0] != 5'h00);
    COV_NEG_OFFSET: cover property (wr_en && addr == `SMC_ADDR_SYNTH_CARRIER_BASE_WORD_OFFSET && wr_data[7]);
    COV_HIGH_WRITE: cover property (wr_en && addr == `SMC_ADDR_CARRIER_WORD_HIGH && wr_data[7:6] != 2'b00);
    COV_READ_BACK: cover property (rd_en ##1 rd_valid && rd_data != 8'h00);
    COV_UNMAPPED_READ: cover property (rd_en && addr > `SMC_ADDR_MODEM_RATE_MANTISSA);

endmodule
`default_nettype wire
